// ==== design/glb_config.sv ====
// Gain-chain configuration bank with APB slave and the small decode and
// combining logic that the register bits steer. Assumes an APB master that
// holds each request until pready, and chain status synchronous to pclk.
//
// Function
// - Bit six picks test clock source
// - Combine bit: sum or larger attenuation
// - Five-bit selector picks test signal
// - Code 0Eh takes DC from alternate page
// - Volume half dB per code, mute above C8h
// - Headroom tracking enable, reset enabled
// - Attack rate doubles from twenty us/dB
// - Limiter enable bit, reset disabled
// - Pause limiter during brownout when set
// - Release rate doubles from four ms/dB
// - Hold time table, code zero reserved
// - Headroom percent, 2.5 percent steps
// - Lowest level: attenuate or mute, shutdown
// - Brownout prevention enable, reset disabled
// - Writing one releases infinite hold, self-clears
// - Combined attenuation cap, high codes disable
// - Infinite hold lasts until release command or brownout disable
`timescale 1ns/1ps
`default_nettype none

module glb_config #(
  parameter int ADDR_W = 12  // APB address width
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire glb_pkg::glb_chain_s  chain,
  output logic      [6:0]           total_atten_db,
  output logic      [7:0]           volume_half_db,
  output logic                      volume_mute,
  output logic      [4:0]           test_signal_select,
  output logic                      test_signal_valid,
  output logic                      test_signal_dc_alt,
  output logic                      test_signal_clock_select,
  output logic                      align_noise_gate_enable,
  output logic                      limiter_run,
  output logic                      limiter_headroom_enable,
  output glb_pkg::glb_timing_s      limiter_timing,
  output logic                      brownout_enable,
  output logic                      brownout_hold,
  output logic                      brownout_mute,
  output logic                      brownout_shutdown
);

  // Register byte address from an index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction : reg_addr

  // Attack rate decode, zero for reserved codes
  function automatic logic [17:0] attack_decode(input logic [3:0] code);
    attack_decode = (code <= glb_pkg::ATK_LAST) ? (glb_pkg::ATK_BASE_US << code) : 18'h00000;
  endfunction : attack_decode

  // Release rate decode, zero for reserved codes
  function automatic logic [13:0] release_decode(input logic [3:0] code);
    release_decode = (code != 4'h0 && code <= glb_pkg::RLS_LAST)
                   ? (glb_pkg::RLS_BASE_MS << (code - 4'h1)) : 14'h0000;
  endfunction : release_decode

  // Hold time table in ms
  function automatic logic [9:0] hold_decode(input logic [2:0] code);
    unique case (code)
      3'h0: hold_decode = 10'h000;  // Reserved
      3'h1: hold_decode = 10'h00A;
      3'h2: hold_decode = 10'h019;
      3'h3: hold_decode = 10'h032;
      3'h4: hold_decode = 10'h064;
      3'h5: hold_decode = 10'h0FA;
      3'h6: hold_decode = 10'h1F4;
      3'h7: hold_decode = 10'h3E8;
    endcase
  endfunction : hold_decode

  // Headroom in signed tenths of a percent, zero when reserved
  function automatic logic [9:0] headroom_decode(input logic [4:0] code);
    headroom_decode = (code <= glb_pkg::HDR_LAST)
                    ? 10'(10'(code) * glb_pkg::HDR_STEP - glb_pkg::HDR_OFFSET) : 10'h000;
  endfunction : headroom_decode

  // Stored registers
  logic [7:0] diag_signal_config;  // Test signal and combine control
  logic [7:0] digital_volume;      // Volume code
  logic [5:0] limiter_config_a;    // Writable bits only
  logic [7:0] limiter_config_b;    // Pause, release, hold
  logic [7:0] brownout_config_a;   // Headroom, shutdown select, enable
  logic [6:0] brownout_config_b;   // Combined cap; release bit not stored

  // Bus phase decode
  wire        setup_phase  = psel & ~penable;
  wire        access_done  = psel & penable & pready;
  wire        do_write     = access_done & pwrite & pstrb[0] & ~pslverr;
  wire [7:0]  wbyte        = pwdata[7:0];

  // Address hits
  wire hit_diag    = (paddr == reg_addr(glb_pkg::IDX_DIAG));
  wire hit_volume  = (paddr == reg_addr(glb_pkg::IDX_VOLUME));
  wire hit_lim_a   = (paddr == reg_addr(glb_pkg::IDX_LIM_A));
  wire hit_lim_b   = (paddr == reg_addr(glb_pkg::IDX_LIM_B));
  wire hit_brown_a = (paddr == reg_addr(glb_pkg::IDX_BROWN_A));
  wire hit_brown_b = (paddr == reg_addr(glb_pkg::IDX_BROWN_B));
  wire hit_status  = (paddr == reg_addr(glb_pkg::IDX_STATUS));
  wire hit_any     = hit_diag | hit_volume | hit_lim_a | hit_lim_b
                   | hit_brown_a | hit_brown_b | hit_status;

  // Write release pulse for the infinite hold
  wire hold_release_wr = do_write & hit_brown_b & wbyte[glb_pkg::BIT_HOLD_REL];

  // Status byte: hold, pause, mute, shutdown, cap active
  wire       limiter_paused;
  wire       cap_active;
  wire [7:0] status_byte = {3'h0, cap_active, brownout_shutdown, brownout_mute,
                            limiter_paused, brownout_hold};

  // Read data mux; reserved bits come back at their fixed values
  wire [7:0] read_byte =
      hit_diag    ? diag_signal_config :
      hit_volume  ? digital_volume :
      hit_lim_a   ? (glb_pkg::LIM_A_RSVD | {2'h0, limiter_config_a}) :
      hit_lim_b   ? limiter_config_b :
      hit_brown_a ? (brownout_config_a & glb_pkg::BROWN_A_MASK) :
      hit_brown_b ? {1'b0, brownout_config_b} :
      hit_status  ? status_byte : 8'h00;

  // APB answer: one wait-free access cycle after setup, data registered in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      prdata  <= setup_phase ? {24'h000000, read_byte} : prdata;
    end
  end

  // Register writes; status and reserved bits ignore writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diag_signal_config <= glb_pkg::RST_DIAG;
      digital_volume     <= glb_pkg::RST_VOLUME;
      limiter_config_a   <= glb_pkg::RST_LIM_A[5:0];
      limiter_config_b   <= glb_pkg::RST_LIM_B;
      brownout_config_a  <= glb_pkg::RST_BROWN_A;
      brownout_config_b  <= glb_pkg::RST_BROWN_B[6:0];
    end
    else if (do_write)
    begin
      // One register per access
      if (hit_diag)    diag_signal_config <= wbyte;
      if (hit_volume)  digital_volume     <= wbyte;
      if (hit_lim_a)   limiter_config_a   <= wbyte[5:0];
      if (hit_lim_b)   limiter_config_b   <= wbyte;
      if (hit_brown_a) brownout_config_a  <= wbyte & glb_pkg::BROWN_A_MASK;
      if (hit_brown_b) brownout_config_b  <= wbyte[6:0];
    end
  end

  // Field views
  wire       combine_max  = diag_signal_config[glb_pkg::BIT_COMBINE];
  wire [4:0] sig_code     = diag_signal_config[4:0];
  wire       limiter_enable       = limiter_config_a[glb_pkg::BIT_LIMITER_ENABLE];
  wire       pause_sel    = limiter_config_b[glb_pkg::BIT_LIM_PAUSE];
  wire       brown_en     = brownout_config_a[glb_pkg::BIT_BROWN_EN];
  wire       shdn_sel     = brownout_config_a[glb_pkg::BIT_BROWN_SHDN];
  wire [6:0] cap_code     = brownout_config_b;

  // Attenuation combining: sum or larger, then cap
  wire [7:0] atten_sum  = {1'b0, chain.limiter_db} + {1'b0, chain.brownout_db};
  wire [7:0] atten_max  = (chain.limiter_db > chain.brownout_db)
                        ? {1'b0, chain.limiter_db} : {1'b0, chain.brownout_db};
  wire [7:0] atten_raw  = combine_max ? atten_max : atten_sum;
  wire       cap_enable = (cap_code <= glb_pkg::CAP_LAST);
  assign     cap_active = cap_enable & (atten_raw > {1'b0, cap_code});
  wire [7:0] atten_sat  = atten_raw[7] ? 8'h7F : atten_raw;
  wire [6:0] next_total = cap_active ? cap_code : atten_sat[6:0];

  // Limiter pause while brownout acts
  assign limiter_paused = limiter_enable & pause_sel & brown_en & chain.brownout_active;

  // Lowest level handling when shutdown is selected
  wire shutdown_trigger = brown_en & shdn_sel & chain.lowest_level;

  // Decoded outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      total_atten_db           <= 7'h00;
      volume_half_db           <= 8'h00;
      volume_mute              <= 1'b0;
      test_signal_select       <= 5'h00;
      test_signal_valid        <= 1'b0;
      test_signal_dc_alt       <= 1'b0;
      test_signal_clock_select <= 1'b0;
      align_noise_gate_enable  <= 1'b0;
      limiter_run              <= 1'b0;
      limiter_headroom_enable  <= 1'b0;
      limiter_timing           <= '0;
      brownout_enable          <= 1'b0;
    end
    else
    begin
      total_atten_db           <= next_total;
      volume_mute              <= (digital_volume > glb_pkg::VOL_LAST);
      volume_half_db           <= (digital_volume > glb_pkg::VOL_LAST) ? glb_pkg::VOL_LAST
                                                                       : digital_volume;
      test_signal_select       <= sig_code;
      test_signal_valid        <= (sig_code <= glb_pkg::SIG_LAST_VALID);
      test_signal_dc_alt       <= (sig_code == glb_pkg::SIG_PROG_DC);
      test_signal_clock_select <= diag_signal_config[glb_pkg::BIT_TCLK_SEL];
      align_noise_gate_enable  <= diag_signal_config[glb_pkg::BIT_ALIGN_NG];
      limiter_run              <= limiter_enable & ~limiter_paused;
      limiter_headroom_enable  <= limiter_config_a[glb_pkg::BIT_HEADROOM_EN];
      limiter_timing.attack_us  <= attack_decode(limiter_config_a[4:1]);
      limiter_timing.release_ms <= release_decode(limiter_config_b[6:3]);
      limiter_timing.hold_ms    <= hold_decode(limiter_config_b[2:0]);
      limiter_timing.headroom   <= headroom_decode(brownout_config_a[7:3]);
      brownout_enable          <= brown_en;
    end
  end

  // Infinite hold: set by the chain, released by software; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brownout_hold <= 1'b0;
    else if (brown_en & chain.hold_start)
      brownout_hold <= 1'b1;
    else if (hold_release_wr | ~brown_en)
      brownout_hold <= 1'b0;
  end

  // Mute first, then shutdown one cycle later; cleared when brownout is disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brownout_mute     <= 1'b0;
      brownout_shutdown <= 1'b0;
    end
    else if (!brown_en)
    begin
      brownout_mute     <= 1'b0;
      brownout_shutdown <= 1'b0;
    end
    else
    begin
      brownout_mute     <= brownout_mute | shutdown_trigger;
      brownout_shutdown <= brownout_shutdown | brownout_mute;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_combine_sum: assert property (
    (!combine_max && !cap_active && !atten_sum[7]) |=> total_atten_db == $past(atten_sum[6:0]))
    else $error("sum mode total wrong");

  a_combine_max: assert property (
    (combine_max && !cap_active) |=> total_atten_db == $past(atten_max[6:0]))
    else $error("max mode total wrong");

  a_cap_limit: assert property (
    cap_enable |=> total_atten_db <= $past(cap_code))
    else $error("cap exceeded");

  a_volume_mute: assert property (
    (digital_volume == 8'hC9) |=> volume_mute)
    else $error("volume above C8h not muted");

  a_volume_pass: assert property (
    (digital_volume <= 8'hC8) |=> !volume_mute && volume_half_db == $past(digital_volume))
    else $error("volume code not passed");

  a_dc_alt: assert property (
    (sig_code == 5'h0E) |=> test_signal_dc_alt && test_signal_valid)
    else $error("programmable DC not flagged");

  a_reserved_sig: assert property (
    (sig_code >= 5'h0F) |=> !test_signal_valid)
    else $error("reserved test code marked valid");

  a_pause_stop: assert property (
    (limiter_enable && pause_sel && brown_en && chain.brownout_active) |=> !limiter_run)
    else $error("limiter not paused");

  a_run_keep: assert property (
    (limiter_enable && !pause_sel) |=> limiter_run)
    else $error("limiter stopped while not paused");

  a_hold_stays: assert property (
    (brownout_hold && brown_en && !hold_release_wr) |=> brownout_hold)
    else $error("hold lost without release");

  a_hold_release: assert property (
    (hold_release_wr && !chain.hold_start) |=> !brownout_hold)
    else $error("hold not released");

  a_shdn_order: assert property (
    ($rose(brownout_mute) && brown_en) |=> brown_en |-> brownout_shutdown)
    else $error("shutdown did not follow mute");

  a_attack_rate: assert property (
    (limiter_config_a[4:1] == 4'hD) |=> limiter_timing.attack_us == 18'h28000)
    else $error("attack rate top code wrong");

  a_release_rate: assert property (
    (limiter_config_b[6:3] == 4'h1) ##1 (limiter_config_b[6:3] == 4'h1)
      |-> limiter_timing.release_ms == 14'h0004)
    else $error("release rate first code wrong");

  a_lim_a_read: assert property (
    (setup_phase && hit_lim_a) |=> prdata[7:6] == 2'b01)
    else $error("reserved bits read wrong");

endmodule : glb_config

`default_nettype wire

// ==== include/glb_pkg.sv ====
// Package for the gain-chain configuration bank: register indices, field positions,
// reset values and the packed structs that carry status in and decoded timing out.
// Assumes an APB byte address of four times the register index.
package glb_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_DIAG     = 8'h19;  // diag_signal_config
  localparam logic [7:0] IDX_VOLUME   = 8'h1A;  // digital_volume
  localparam logic [7:0] IDX_LIM_A    = 8'h1B;  // limiter_config_a
  localparam logic [7:0] IDX_LIM_B    = 8'h1C;  // limiter_config_b
  localparam logic [7:0] IDX_BROWN_A  = 8'h1D;  // brownout_config_a
  localparam logic [7:0] IDX_BROWN_B  = 8'h1E;  // brownout_config_b
  localparam logic [7:0] IDX_STATUS   = 8'h30;  // Block status, read only

  // Reset values
  localparam logic [7:0] RST_DIAG     = 8'h0D;
  localparam logic [7:0] RST_VOLUME   = 8'h00;
  localparam logic [7:0] RST_LIM_A    = 8'h62;
  localparam logic [7:0] RST_LIM_B    = 8'h32;
  localparam logic [7:0] RST_BROWN_A  = 8'h40;
  localparam logic [7:0] RST_BROWN_B  = 8'h32;

  // Field positions
  localparam int BIT_ALIGN_NG     = 7;  // diag: align_noise_gate_enable
  localparam int BIT_TCLK_SEL     = 6;  // diag: test_signal_clock_select
  localparam int BIT_COMBINE      = 5;  // diag: attenuation_combine_mode
  localparam int BIT_HEADROOM_EN  = 5;  // lim_a: limiter_headroom_enable
  localparam int BIT_LIMITER_ENABLE       = 0;  // lim_a: limiter_enable
  localparam int BIT_LIM_PAUSE    = 7;  // lim_b: limiter_pause_in_brownout
  localparam int BIT_BROWN_SHDN   = 1;  // brown_a: brownout_shutdown_select
  localparam int BIT_BROWN_EN     = 0;  // brown_a: brownout_enable
  localparam int BIT_HOLD_REL     = 7;  // brown_b: brownout_hold_release

  // Fixed reserved patterns and writable masks
  localparam logic [7:0] LIM_A_RSVD   = 8'h40;  // Bits 7:6 read as 01
  localparam logic [7:0] LIM_A_MASK   = 8'h3F;
  localparam logic [7:0] BROWN_A_MASK = 8'hFB;  // Bit 2 reserved, reads 0
  localparam logic [7:0] BROWN_B_MASK = 8'h7F;  // Bit 7 self-clearing

  // Code limits
  localparam logic [4:0] SIG_PROG_DC    = 5'h0E;  // DC from alternate page
  localparam logic [4:0] SIG_LAST_VALID = 5'h0E;
  localparam logic [7:0] VOL_LAST       = 8'hC8;  // Above this: mute
  localparam logic [3:0] ATK_LAST       = 4'hD;
  localparam logic [3:0] RLS_LAST       = 4'hC;
  localparam logic [4:0] HDR_LAST       = 5'h10;
  localparam logic [6:0] CAP_LAST       = 7'h2E;  // Above this: no cap
  localparam logic [17:0] ATK_BASE_US   = 18'h00014;  // 20 us/dB
  localparam logic [13:0] RLS_BASE_MS   = 14'h0004;   // 4 ms/dB
  localparam logic [9:0] HDR_STEP       = 10'h019;    // 2.5 % in tenths
  localparam logic [9:0] HDR_OFFSET     = 10'h0C8;    // 20 % in tenths

  // Attenuation and brownout status from the gain chain
  typedef struct packed {
    logic       brownout_active;  // Brownout prevention acting
    logic       lowest_level;     // Lowest brownout level reached
    logic       hold_start;       // Infinite hold begins (pulse)
    logic [6:0] brownout_db;      // Brownout attenuation, 1 dB steps
    logic [6:0] limiter_db;       // Limiter attenuation, 1 dB steps
  } glb_chain_s;

  // Decoded limiter timing; reserved codes decode to zero
  typedef struct packed {
    logic [17:0] attack_us;     // us per dB
    logic [13:0] release_ms;    // ms per dB
    logic [9:0]  hold_ms;       // Hold time in ms
    logic [9:0]  headroom;      // Signed, tenths of a percent
  } glb_timing_s;

endpackage : glb_pkg

// ==== tb/test_gain_limiter_brownout_config.sv ====
// Testbench for the gain-chain configuration bank: APB tasks and directed checks.
// Assumes an answer with pready and decoded outputs that lag the registers by one clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module test_gain_limiter_brownout_config;
  logic                 pclk;        // Bus clock
  logic                 presetn;     // Active-low reset
  logic                 psel;        // APB select
  logic                 penable;     // APB access phase
  logic                 pwrite;      // APB direction
  logic [11:0]          paddr;       // Byte address
  logic [31:0]          pwdata;      // Write data
  logic [3:0]           pstrb;       // Byte strobes
  logic [31:0]          prdata;      // Read data
  logic                 pready;      // Slave answer
  logic                 pslverr;     // Slave error
  glb_pkg::glb_chain_s  chain;       // Chain status stimulus
  logic [6:0]           total_atten_db;
  logic [7:0]           volume_half_db;
  logic                 volume_mute;
  logic [4:0]           test_signal_select;
  logic                 test_signal_valid;
  logic                 test_signal_dc_alt;
  logic                 test_signal_clock_select;
  logic                 align_noise_gate_enable;
  logic                 limiter_run;
  logic                 limiter_headroom_enable;
  glb_pkg::glb_timing_s limiter_timing;
  logic                 brownout_enable;
  logic                 brownout_hold;
  logic                 brownout_mute;
  logic                 brownout_shutdown;
  int                   num_errors;  // Mismatches
  int                   n_checks;    // Comparisons
  logic [7:0]           rd;          // Last read byte
  logic                 err;         // Last error flag
  logic [9:0]           hold_tab [8] = '{10'h000, 10'h00A, 10'h019, 10'h032, 10'h064, 10'h0FA, 10'h1F4, 10'h3E8};
  logic [7:0]           vols [5]     = '{8'h00, 8'h01, 8'hC8, 8'hC9, 8'hFF};
  logic [4:0]           sigs [6]     = '{5'h00, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h1F};
  // Combine cases: diag, cap, limiter dB, brownout dB, expected total
  logic [39:0]          cmb [6]      = '{40'h0D7F0A0711, 40'h2D7F0A070A, 40'h0D050A0705,
                                         40'h0D2E64642E, 40'h0D2F64647F, 40'h2D2F143C3C};

  glb_config glb_config_i (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .chain                    (chain),
    .total_atten_db           (total_atten_db),
    .volume_half_db           (volume_half_db),
    .volume_mute              (volume_mute),
    .test_signal_select       (test_signal_select),
    .test_signal_valid        (test_signal_valid),
    .test_signal_dc_alt       (test_signal_dc_alt),
    .test_signal_clock_select (test_signal_clock_select),
    .align_noise_gate_enable  (align_noise_gate_enable),
    .limiter_run              (limiter_run),
    .limiter_headroom_enable  (limiter_headroom_enable),
    .limiter_timing           (limiter_timing),
    .brownout_enable          (brownout_enable),
    .brownout_hold            (brownout_hold),
    .brownout_mute            (brownout_mute),
    .brownout_shutdown        (brownout_shutdown)
  );

  // Free-running 50 MHz clock
  always #10 pclk = ~pclk;

  // Prints counts and verdict, then ends the run
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] strb);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("BAD pready expected 1 seen %b", pready);
      stop_test();
    end
    rd      = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write with the low strobe set
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'h1);
  endtask : wr

  // Register read compared with an expected byte
  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] ex);
    apb(1'b0, idx, 8'h00, 4'h0);
    `CHK("register", ex, rd)
  endtask : chk_rd

  // Lets a stored write reach the decoded outputs
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  // One-cycle infinite-hold start from the chain
  task automatic pulse_hold();
    chain.hold_start <= 1'b1;
    @(posedge pclk);
    chain.hold_start <= 1'b0;
    settle();
  endtask : pulse_hold

  // Main sequence
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; chain = '0; num_errors = 0; n_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `CHK("headroom_en", 1'b1, limiter_headroom_enable)
    `CHK("limiter_run", 1'b0, limiter_run)
    chk_rd(8'h19, 8'h0D);
    chk_rd(8'h1A, 8'h00);
    chk_rd(8'h1B, 8'h62);
    chk_rd(8'h1C, 8'h32);
    chk_rd(8'h1D, 8'h40);
    chk_rd(8'h1E, 8'h32);
    wr(8'h1B, 8'hFF);
    chk_rd(8'h1B, 8'h7F);
    wr(8'h1D, 8'hFF);
    chk_rd(8'h1D, 8'hFB);
    apb(1'b0, 8'h1F, 8'h00, 4'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 8'h00, rd)
    // Limiter timing decode over every code
    for (int c = 0; c < 32; c++)
    begin
      wr(8'h1B, {3'h1, c[3:0], 1'b0});
      wr(8'h1C, {1'b0, c[3:0], c[2:0]});
      wr(8'h1D, {c[4:0], 3'h0});
      settle();
      `CHK("attack_us", (c[3:0] <= 13) ? (18'h00014 << c[3:0]) : 18'h0, limiter_timing.attack_us)
      `CHK("release_ms", (c[3:0] >= 1 && c[3:0] <= 12) ? (14'h0004 << (c[3:0] - 1)) : 14'h0, limiter_timing.release_ms)
      `CHK("hold_ms", hold_tab[c[2:0]], limiter_timing.hold_ms)
      `CHK("headroom", (c <= 16) ? 10'(c * 10'h019 - 10'h0C8) : 10'h000, limiter_timing.headroom)
    end
    // Volume codes around the mute boundary
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h1A, vols[i]);
      settle();
      `CHK("volume", (vols[i] > 8'hC8) ? 8'hC8 : vols[i], volume_half_db)
      `CHK("mute", vols[i] > 8'hC8, volume_mute)
    end
    apb(1'b1, 8'h1A, 8'h55, 4'h0);
    chk_rd(8'h1A, 8'hFF);
    // Test signal selector and its companion bits
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h19, {i[0], i[1], 1'b0, sigs[i]});
      settle();
      chk_rd(8'h19, {i[0], i[1], 1'b0, sigs[i]});
      `CHK("sig_select", sigs[i], test_signal_select)
      `CHK("sig_valid", sigs[i] <= 5'h0E, test_signal_valid)
      `CHK("sig_dc_alt", sigs[i] == 5'h0E, test_signal_dc_alt)
      `CHK("clock_select", i[1], test_signal_clock_select)
      `CHK("align_ng", i[0], align_noise_gate_enable)
    end
    // Attenuation combining and cap
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h19, cmb[i][39:32]);
      wr(8'h1E, cmb[i][31:24]);
      chain.limiter_db  <= cmb[i][22:16];
      chain.brownout_db <= cmb[i][14:8];
      settle();
      `CHK("total_atten", cmb[i][6:0], total_atten_db)
    end
    // Limiter enable and pause during brownout
    wr(8'h1B, 8'h63);
    wr(8'h1C, 8'hB2);
    wr(8'h1D, 8'h41);
    chain.brownout_active <= 1'b1;
    settle();
    `CHK("brownout_en", 1'b1, brownout_enable)
    `CHK("limiter_run", 1'b0, limiter_run)
    chk_rd(8'h30, 8'h02);
    wr(8'h1C, 8'h32);
    settle();
    `CHK("limiter_run", 1'b1, limiter_run)
    wr(8'h1B, 8'h62);
    settle();
    `CHK("limiter_run", 1'b0, limiter_run)
    @(posedge pclk);
    chain.brownout_active <= 1'b0;
    // Infinite hold and its self-clearing release
    pulse_hold();
    repeat (20) @(posedge pclk);
    `CHK("hold", 1'b1, brownout_hold)
    chk_rd(8'h1E, 8'h2F);
    wr(8'h1E, 8'hAF);
    settle();
    `CHK("hold", 1'b0, brownout_hold)
    chk_rd(8'h1E, 8'h2F);
    wr(8'h1D, 8'h40);
    pulse_hold();
    `CHK("hold_off", 1'b0, brownout_hold)
    // Lowest level: mute and shutdown, or attenuate only
    wr(8'h1D, 8'h43);
    chain.lowest_level <= 1'b1;
    settle();
    @(posedge pclk);
    #1;
    `CHK("bo_mute", 1'b1, brownout_mute)
    `CHK("bo_shutdown", 1'b1, brownout_shutdown)
    wr(8'h1D, 8'h40);
    wr(8'h1D, 8'h41);
    settle();
    `CHK("bo_mute", 1'b0, brownout_mute)
    `CHK("bo_shutdown", 1'b0, brownout_shutdown)
    chain.lowest_level <= 1'b0;
    stop_test();
  end
endmodule : test_gain_limiter_brownout_config

`default_nettype wire
